/* dual_analog_out_param_diag.sv */
// Parameter and diagnostic record bank of a two-channel voltage output module
//
// How it works
// - Short-detect enable byte, bits 0/1, reset zero
// - Channel range code resets to 12h
// - Range code FFh switches channel off
// - Code 12h: bipolar, 27648 full, clamp 7EFF/8100
// - Code 22h: bipolar, 16384 full, clamp 5000/B000
// - Code 10h: unipolar 27648 scale, negatives give 0V
// - Code 20h: unipolar 16384 scale, negatives give 0V
// - No interrupt; errors light group LED, channel faults channel LED, recorded
// - Report config errors; shorts only when enabled
// - General byte: fail,int,ext,chan,aux,param bits
// - Module class byte reads constant 15h
// - Internal byte: buffer overflow bit3, comm bit4
// - Constants 73h, 08h, 02h in record
// - Group byte bit per faulty channel
// - Channel byte: cfg bit0, short bit3, rest zero
// - Timestamp captured when diagnostic event recorded
// - 32-bit microsecond ticker from zero, wrapping
`timescale 1ns/1ps
`include "dual_ao_regs.svh"
module dual_analog_out_param_diag import dual_ao_pkg::*; (
	input  wire logic               core_clk_in,
	input  wire logic               sys_rst_in,
	input  wire param_wr_s          param_wr_in,
	input  wire rd_req_s            rd_req_in,
	input  wire logic [1:0][15:0]   out_value_in,
	input  wire logic [1:0]         short_pin_in,
	input  wire logic               aux_missing_pin_in,
	input  wire logic               module_fail_in,
	input  wire logic               internal_err_in,
	input  wire logic               diag_overflow_in,
	input  wire logic               comm_err_in,
	output logic [7:0]              rd_data_out,
	output logic                    rd_valid_out,
	output logic [1:0][15:0]        dac_code_out,
	output logic [1:0]              chan_enable_out,
	output logic [1:0]              chan_led_out,
	output logic                    group_led_out
);
	// Parameter registers
	logic [7:0]       short_detect_enable_ff;
	logic [1:0][7:0]  chan_range_code_ff;

	// Pin synchronisers
	logic [1:0]       short_meta_ff;
	logic [1:0]       short_sync_ff;
	logic             aux_meta_ff;
	logic             aux_sync_ff;

	// Diagnostic record state
	general_flags_s   diag_general_flags_ff;
	general_flags_s   nxt_general;
	internal_flags_s  diag_internal_flags_ff;
	internal_flags_s  nxt_internal;
	chan_fault_s [1:0] chan_fault_flags_ff;
	chan_fault_s [1:0] nxt_chan_fault;
	logic [7:0]       channel_group_errors_ff;
	logic [7:0]       nxt_group;
	logic [31:0]      diag_timestamp_us_ff;
	logic             record_change;

	// Read port
	logic [7:0]       nxt_rd_data;
	logic [7:0]       rd_data_ff;
	logic             rd_valid_ff;
	logic [1:0]       led_ff;
	logic             group_led_ff;

	// Sub-block results
	logic [31:0]      ticks_us;
	logic [1:0]       chan_active;
	logic [1:0]       chan_cfg_err;

	// Parameter writes; the reserved byte keeps no state
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			short_detect_enable_ff <= `RST_SHORT_EN;
		end else if (param_wr_in.valid && param_wr_in.idx == `PIDX_SHORT_EN) begin
			short_detect_enable_ff <= param_wr_in.data & `SHORT_EN_MASK;
		end
	end

	// Range codes, stored as written so bad codes stay visible
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			chan_range_code_ff[0] <= `RST_RANGE;
			chan_range_code_ff[1] <= `RST_RANGE;
		end else if (param_wr_in.valid) begin
			if (param_wr_in.idx == `PIDX_CH0_RANGE) chan_range_code_ff[0] <= param_wr_in.data;
			if (param_wr_in.idx == `PIDX_CH1_RANGE) chan_range_code_ff[1] <= param_wr_in.data;
		end
	end

	// Short comparators and aux sense are asynchronous pins
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			short_meta_ff <= 2'h0;
			short_sync_ff <= 2'h0;
			aux_meta_ff   <= 1'b0;
			aux_sync_ff   <= 1'b0;
		end else begin
			short_meta_ff <= short_pin_in;
			short_sync_ff <= short_meta_ff;
			aux_meta_ff   <= aux_missing_pin_in;
			aux_sync_ff   <= aux_meta_ff;
		end
	end

	// One scaler per channel
	generate
		for (genvar ch = 0; ch < 2; ch++) begin : g_chan
			range_scaler u_scaler (
				.core_clk_in   (core_clk_in),
				.sys_rst_in    (sys_rst_in),
				.range_code_in (chan_range_code_ff[ch]),
				.value_in      (out_value_in[ch]),
				.dac_code_out  (dac_code_out[ch]),
				.active_out    (chan_active[ch]),
				.cfg_err_out   (chan_cfg_err[ch])
			);
		end
	endgenerate

	assign chan_enable_out = chan_active;

	us_ticker u_ticker (
		.core_clk_in  (core_clk_in),
		.sys_rst_in   (sys_rst_in),
		.ticks_us_out (ticks_us)
	);

	// Per-channel faults; a short on a disabled channel stays silent
	always_comb begin
		for (int ch = 0; ch < 2; ch++) begin
			nxt_chan_fault[ch]           = '0;
			nxt_chan_fault[ch].cfg_err   = chan_cfg_err[ch];
			nxt_chan_fault[ch].short_gnd = short_sync_ff[ch] &
			                               short_detect_enable_ble(ch);
		end
	end

	// Enable bit lookup for one channel
	function automatic logic short_detect_enable_ble(input int ch);
		short_detect_enable_ble = short_detect_enable_ff[ch];
	endfunction

	// Summaries track the live faults and drop when they go
	always_comb begin
		nxt_group    = 8'h00;
		nxt_group[0] = |nxt_chan_fault[0];
		nxt_group[1] = |nxt_chan_fault[1];
		nxt_general             = '0;
		nxt_general.module_fail = module_fail_in;
		nxt_general.internal    = internal_err_in | diag_overflow_in | comm_err_in;
		nxt_general.external    = nxt_chan_fault[0].short_gnd |
		                          nxt_chan_fault[1].short_gnd | aux_sync_ff;
		nxt_general.channel     = |nxt_group;
		nxt_general.aux_missing = aux_sync_ff;
		nxt_general.param_err   = |chan_cfg_err;
		nxt_internal            = '0;
		nxt_internal.buf_ovf    = diag_overflow_in;
		nxt_internal.comm_err   = comm_err_in;
	end

	// A new record is any change of the live error bytes
	assign record_change = (nxt_general != diag_general_flags_ff) ||
	                       (nxt_internal != diag_internal_flags_ff) ||
	                       (nxt_chan_fault != chan_fault_flags_ff);

	// Diagnostic record update; no interrupt is ever raised
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			diag_general_flags_ff   <= '0;
			diag_internal_flags_ff  <= '0;
			chan_fault_flags_ff     <= '0;
			channel_group_errors_ff <= 8'h00;
		end else begin
			diag_general_flags_ff   <= nxt_general;
			diag_internal_flags_ff  <= nxt_internal;
			chan_fault_flags_ff     <= nxt_chan_fault;
			channel_group_errors_ff <= nxt_group;
		end
	end

	// Timestamp of the latest record change
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			diag_timestamp_us_ff <= 32'h0000_0000;
		end else if (record_change) begin
			diag_timestamp_us_ff <= ticks_us;
		end
	end

	// Channel LEDs follow the recorded channel bytes, group LED the general byte
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			led_ff       <= 2'h0;
			group_led_ff <= 1'b0;
		end else begin
			led_ff[0]    <= |nxt_chan_fault[0];
			led_ff[1]    <= |nxt_chan_fault[1];
			group_led_ff <= |nxt_general;
		end
	end

	assign chan_led_out  = led_ff;
	assign group_led_out = group_led_ff;

	// Read mux; unused channel bytes and holes read zero
	always_comb begin
		nxt_rd_data = 8'h00;
		if (!rd_req_in.space) begin
			case (rd_req_in.idx)
				{3'h0, `PIDX_SHORT_EN}:  nxt_rd_data = short_detect_enable_ff;
				{3'h0, `PIDX_CH0_RANGE}: nxt_rd_data = chan_range_code_ff[0];
				{3'h0, `PIDX_CH1_RANGE}: nxt_rd_data = chan_range_code_ff[1];
				default:                 nxt_rd_data = 8'h00;
			endcase
		end else begin
			case (rd_req_in.idx)
				`DIDX_GENERAL:  nxt_rd_data = diag_general_flags_ff;
				`DIDX_MODCLASS: nxt_rd_data = `MODCLASS_VAL;
				`DIDX_INTERNAL: nxt_rd_data = diag_internal_flags_ff;
				`DIDX_CHKIND:   nxt_rd_data = `CHKIND_VAL;
				`DIDX_BITS:     nxt_rd_data = `BITS_VAL;
				`DIDX_COUNT:    nxt_rd_data = `COUNT_VAL;
				`DIDX_GROUP:    nxt_rd_data = channel_group_errors_ff;
				`DIDX_CH0:      nxt_rd_data = chan_fault_flags_ff[0];
				`DIDX_CH1:      nxt_rd_data = chan_fault_flags_ff[1];
				`DIDX_TS0:      nxt_rd_data = diag_timestamp_us_ff[7:0];
				`DIDX_TS1:      nxt_rd_data = diag_timestamp_us_ff[15:8];
				`DIDX_TS2:      nxt_rd_data = diag_timestamp_us_ff[23:16];
				`DIDX_TS3:      nxt_rd_data = diag_timestamp_us_ff[31:24];
				default:        nxt_rd_data = 8'h00;
			endcase
		end
	end

	// Read answer one cycle after the request
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			rd_data_ff  <= 8'h00;
			rd_valid_ff <= 1'b0;
		end else begin
			rd_data_ff  <= rd_req_in.valid ? nxt_rd_data : 8'h00;
			rd_valid_ff <= rd_req_in.valid;
		end
	end

	assign rd_data_out  = rd_data_ff;
	assign rd_valid_out = rd_valid_ff;

	// Checks on the recorded state
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (sys_rst_in);

	a_short_en_write: assert property (
		param_wr_in.valid && param_wr_in.idx == `PIDX_SHORT_EN
		|=> short_detect_enable_ff == ($past(param_wr_in.data) & `SHORT_EN_MASK))
		else $error("short enable byte not stored");

	a_off_disables: assert property (
		chan_range_code_ff[0] == `RANGE_OFF && $stable(chan_range_code_ff[0])
		|=> !chan_enable_out[0] && dac_code_out[0] == `DAC_MIDSCALE)
		else $error("channel 0 not off at code FF");

	a_short_gated: assert property (
		!short_detect_enable_ff[1] |=> !chan_fault_flags_ff[1].short_gnd)
		else $error("short reported on disabled channel");

	a_short_reported: assert property (
		short_sync_ff[0] && short_detect_enable_ff[0]
		|=> chan_fault_flags_ff[0].short_gnd && channel_group_errors_ff[0]
		    && diag_general_flags_ff.channel)
		else $error("enabled short not reported");

	a_bad_code_flag: assert property (
		$changed(chan_range_code_ff[1]) && !(chan_range_code_ff[1] inside
		{`RANGE_BI_N27, `RANGE_BI_N16, `RANGE_UNI_N27, `RANGE_UNI_N16, `RANGE_OFF})
		|=> ##1 diag_general_flags_ff.param_err && chan_fault_flags_ff[1].cfg_err)
		else $error("bad range code not flagged");

	a_internal_bits: assert property (
		diag_overflow_in && !comm_err_in
		|=> diag_internal_flags_ff == 8'h08)
		else $error("internal byte wrong on overflow");

	a_group_clears: assert property (
		nxt_chan_fault[0] == '0 && nxt_chan_fault[1] == '0
		|=> channel_group_errors_ff == 8'h00 && !diag_general_flags_ff.channel)
		else $error("channel summary stuck");

	a_stamp_capture: assert property (
		record_change |=> diag_timestamp_us_ff == $past(ticks_us))
		else $error("timestamp not captured on change");

	a_ticker_step: assert property (
		$changed(ticks_us) |-> ticks_us == $past(ticks_us) + 32'h0000_0001)
		else $error("ticker did not step by one");

	a_const_bytes: assert property (
		rd_req_in.valid && rd_req_in.space && rd_req_in.idx == `DIDX_MODCLASS
		|=> rd_valid_out && rd_data_out == `MODCLASS_VAL)
		else $error("module class read wrong");
endmodule // dual_analog_out_param_diag

/* dual_ao_regs.svh */
// Byte indices, reset values, range codes and timing counts of the parameter/diagnostic bank
`ifndef DUAL_AO_REGS_SVH
`define DUAL_AO_REGS_SVH

// Parameter record byte indices
`define PIDX_RESERVED     2'h0
`define PIDX_SHORT_EN     2'h1
`define PIDX_CH0_RANGE    2'h2
`define PIDX_CH1_RANGE    2'h3

// Diagnostic record byte indices
`define DIDX_GENERAL      5'h00
`define DIDX_MODCLASS     5'h01
`define DIDX_RESERVED     5'h02
`define DIDX_INTERNAL     5'h03
`define DIDX_CHKIND       5'h04
`define DIDX_BITS         5'h05
`define DIDX_COUNT        5'h06
`define DIDX_GROUP        5'h07
`define DIDX_CH0          5'h08
`define DIDX_CH1          5'h09
`define DIDX_TS0          5'h10
`define DIDX_TS1          5'h11
`define DIDX_TS2          5'h12
`define DIDX_TS3          5'h13

// Reset and constant values
`define RST_SHORT_EN      8'h00
`define RST_RANGE         8'h12
`define SHORT_EN_MASK     8'h03
`define MODCLASS_VAL      8'h15
`define CHKIND_VAL        8'h73
`define BITS_VAL          8'h08
`define COUNT_VAL         8'h02

// Range selection codes
`define RANGE_BI_N27      8'h12
`define RANGE_BI_N16      8'h22
`define RANGE_UNI_N27     8'h10
`define RANGE_UNI_N16     8'h20
`define RANGE_OFF         8'hff

// Code limits per format
`define N27_OVER          16'h7eff
`define N27_UNDER         16'h8100
`define N16_OVER          16'h5000
`define N16_UNDER         16'hb000

// Q14 gains to a 16-bit DAC spanning +-12.5 V, offset binary
`define SCALE_N27         16'h3caf
`define SCALE_N16         16'h6666
`define DAC_MIDSCALE      16'h8000
`define DAC_POS_MAX       18'sh0_7fff
`define DAC_NEG_MIN       18'sh3_8000

// Microsecond ticker timing
`define US_TIME_NS        1000
`define CLK_PERIOD_NS     25
`define TICKS_PER_US      ((`US_TIME_NS) / (`CLK_PERIOD_NS))

`endif

/* dual_ao_pkg.sv */
// Types shared by the parameter/diagnostic bank
package dual_ao_pkg;

	// Parameter byte write from the coupler
	typedef struct packed {
		logic       valid;
		logic [1:0] idx;
		logic [7:0] data;
	} param_wr_s;

	// Record read request: space 0 parameters, 1 diagnostics
	typedef struct packed {
		logic       valid;
		logic       space;
		logic [4:0] idx;
	} rd_req_s;

	// First diagnostic byte
	typedef struct packed {
		logic       param_err;
		logic [1:0] rsv;
		logic       aux_missing;
		logic       channel;
		logic       external;
		logic       internal;
		logic       module_fail;
	} general_flags_s;

	// Fourth diagnostic byte
	typedef struct packed {
		logic [2:0] rsv_hi;
		logic       comm_err;
		logic       buf_ovf;
		logic [2:0] rsv_lo;
	} internal_flags_s;

	// Per-channel error byte
	typedef struct packed {
		logic [3:0] rsv_hi;
		logic       short_gnd;
		logic [1:0] rsv_lo;
		logic       cfg_err;
	} chan_fault_s;

	// Decoded range format
	typedef enum logic [2:0] {
		FMT_OFF,
		FMT_BI_N27,
		FMT_BI_N16,
		FMT_UNI_N27,
		FMT_UNI_N16,
		FMT_BAD
	} range_fmt_e;

endpackage

/* us_ticker.sv */
// Free-running 32-bit microsecond ticker
`timescale 1ns/1ps
`include "dual_ao_regs.svh"
module us_ticker import dual_ao_pkg::*; (
	input  wire logic        core_clk_in,
	input  wire logic        sys_rst_in,
	output logic [31:0]      ticks_us_out
);
	localparam logic [5:0] PRE_LAST = 6'(`TICKS_PER_US - 1);

	logic [5:0]  pre_ff;
	logic [31:0] count_ff;

	// Prescaler divides the core clock down to 1 us
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in || pre_ff == PRE_LAST) begin
			pre_ff <= 6'h00;
		end else begin
			pre_ff <= pre_ff + 6'h01;
		end
	end

	// Counts from zero, wraps naturally past all ones
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			count_ff <= 32'h0000_0000;
		end else if (pre_ff == PRE_LAST) begin
			count_ff <= count_ff + 32'h0000_0001;
		end
	end

	assign ticks_us_out = count_ff;
endmodule // us_ticker

/* range_scaler.sv */
// Per-channel range decode, clamping and scaling to the DAC code
`timescale 1ns/1ps
`include "dual_ao_regs.svh"
module range_scaler import dual_ao_pkg::*; (
	input  wire logic               core_clk_in,
	input  wire logic               sys_rst_in,
	input  wire logic [7:0]         range_code_in,
	input  wire logic signed [15:0] value_in,
	output logic [15:0]             dac_code_out,
	output logic                    active_out,
	output logic                    cfg_err_out
);
	range_fmt_e         fmt;
	logic signed [15:0] clamped;
	logic signed [15:0] gain;
	logic signed [31:0] prod;
	logic signed [17:0] scaled;
	logic [15:0]        sat;

	// Range code decode; unknown codes fall to FMT_BAD
	always_comb begin
		case (range_code_in)
			`RANGE_BI_N27:  fmt = FMT_BI_N27;
			`RANGE_BI_N16:  fmt = FMT_BI_N16;
			`RANGE_UNI_N27: fmt = FMT_UNI_N27;
			`RANGE_UNI_N16: fmt = FMT_UNI_N16;
			`RANGE_OFF:    fmt = FMT_OFF;
			default:       fmt = FMT_BAD;
		endcase
	end

	// Clamp to the over/underrange ends of each format
	always_comb begin
		clamped = value_in;
		gain    = $signed(`SCALE_N27);
		case (fmt)
			FMT_BI_N27, FMT_UNI_N27: begin
				if (value_in > $signed(`N27_OVER)) clamped = $signed(`N27_OVER);
				if (fmt == FMT_BI_N27 && value_in < $signed(`N27_UNDER)) begin
					clamped = $signed(`N27_UNDER);
				end
			end
			FMT_BI_N16, FMT_UNI_N16: begin
				gain = $signed(`SCALE_N16);
				if (value_in > $signed(`N16_OVER)) clamped = $signed(`N16_OVER);
				if (fmt == FMT_BI_N16 && value_in < $signed(`N16_UNDER)) begin
					clamped = $signed(`N16_UNDER);
				end
			end
			default: clamped = 16'sh0000;
		endcase
		// Unipolar formats have no underrange, negative codes give 0 V
		if ((fmt == FMT_UNI_N27 || fmt == FMT_UNI_N16) && value_in < 0) begin
			clamped = 16'sh0000;
		end
	end

	// Q14 gain; +20480 in the 16384 format nears the DAC top, so saturate
	assign prod   = clamped * gain;
	assign scaled = prod[31:14];
	assign sat    = (scaled > `DAC_POS_MAX) ? 16'h7fff :
	                (scaled < `DAC_NEG_MIN) ? 16'h8000 : scaled[15:0];

	// Registered DAC code; off or bad channels park at midscale
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			dac_code_out <= `DAC_MIDSCALE;
			active_out   <= 1'b0;
			cfg_err_out  <= 1'b0;
		end else begin
			dac_code_out <= (fmt == FMT_OFF || fmt == FMT_BAD) ?
			                `DAC_MIDSCALE : (sat ^ `DAC_MIDSCALE);
			active_out   <= (fmt != FMT_OFF) && (fmt != FMT_BAD);
			cfg_err_out  <= (fmt == FMT_BAD);
		end
	end
endmodule // range_scaler

/* coupler_model.sv */
// Behavioural coupler that issues parameter writes and record reads
`timescale 1ns/1ps
module coupler_model import dual_ao_pkg::*; (
	input  wire logic       core_clk_in,
	input  wire logic       sys_rst_in,
	input  wire logic       go_in,
	input  wire logic       write_in,
	input  wire logic       space_in,
	input  wire logic [4:0] idx_in,
	input  wire logic [7:0] data_in,
	input  wire logic [7:0] rd_data_in,
	input  wire logic       rd_valid_in,
	output param_wr_s       param_wr_out,
	output rd_req_s         rd_req_out,
	output logic [7:0]      resp_out,
	output logic            resp_valid_out
);
	// One-cycle request; idle idx and data inverted so stale values never pass for live ones
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			param_wr_out   <= '0;
			rd_req_out     <= '0;
			resp_valid_out <= 1'b0;
			resp_out       <= 8'h00;
		end else begin
			param_wr_out.valid <= go_in & write_in;
			param_wr_out.idx   <= go_in ? idx_in[1:0] : ~param_wr_out.idx;
			param_wr_out.data  <= go_in ? data_in : ~param_wr_out.data;
			rd_req_out.valid   <= go_in & ~write_in;
			rd_req_out.space   <= space_in;
			rd_req_out.idx     <= go_in ? idx_in : ~rd_req_out.idx;
			// Answer taken at the edge that shows read valid
			resp_valid_out     <= rd_valid_in | param_wr_out.valid;
			if (rd_valid_in) begin
				resp_out <= rd_data_in;
			end
		end
	end
endmodule // coupler_model

/* testbench.sv */
// Self-checking bench of the parameter and diagnostic bank
`timescale 1ns/1ps
`include "dual_ao_regs.svh"
module testbench import dual_ao_pkg::*;;
	logic             clk, rst, go, wr, sp, rdv, resp_v, gled;
	logic [4:0]       ix, flt;
	logic [7:0]       dt, rdd, resp;
	logic [15:0]      seed, v;
	logic [31:0]      ts;
	logic [1:0][15:0] val, dac;
	logic [1:0]       short, en, led;
	param_wr_s        pw;
	rd_req_s          rq;
	int               num_errors, cmp_count, cyc, t0;
	localparam logic [7:0]  codes [4] = '{8'h12, 8'h22, 8'h10, 8'h20};
	localparam logic [15:0] corner [4] = '{16'h7fff, 16'h8000, 16'h6c00, 16'hffff};
	localparam logic [7:0]  gen_e [5] = '{8'h01, 8'h02, 8'h02, 8'h02, 8'h14};
	localparam logic [7:0]  int_e [5] = '{8'h00, 8'h00, 8'h08, 8'h10, 8'h00};

	coupler_model partner (.core_clk_in(clk), .sys_rst_in(rst), .go_in(go), .write_in(wr),
		.space_in(sp), .idx_in(ix), .data_in(dt), .rd_data_in(rdd), .rd_valid_in(rdv),
		.param_wr_out(pw), .rd_req_out(rq), .resp_out(resp), .resp_valid_out(resp_v));
	dual_analog_out_param_diag dut (.core_clk_in(clk), .sys_rst_in(rst), .param_wr_in(pw),
		.rd_req_in(rq), .out_value_in(val), .short_pin_in(short),
		.aux_missing_pin_in(flt[4]), .module_fail_in(flt[0]), .internal_err_in(flt[1]),
		.diag_overflow_in(flt[2]), .comm_err_in(flt[3]), .rd_data_out(rdd),
		.rd_valid_out(rdv), .dac_code_out(dac), .chan_enable_out(en),
		.chan_led_out(led), .group_led_out(gled));

	// 40 MHz clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Cycles since reset release, matches the ticker origin
	always @(posedge clk) cyc <= rst ? 0 : cyc + 1;

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// Constant diagnostic bytes after reset
	function automatic logic [7:0] rst_diag(input int i);
		case (i)
			1: return 8'h15;
			4: return 8'h73;
			5: return 8'h08;
			6: return 8'h02;
			default: return 8'h00;
		endcase
	endfunction
	// Clamp, scale and offset the way each range format asks
	function automatic logic [15:0] exp_dac(input logic [7:0] c, input logic signed [15:0] d);
		logic signed [31:0] p;
		logic signed [15:0] hi, lo;
		logic [15:0]        g;
		if (c == 8'h12 || c == 8'h10) begin
			hi = `N27_OVER;
			lo = `N27_UNDER;
			g = `SCALE_N27;
		end else if (c == 8'h22 || c == 8'h20) begin
			hi = `N16_OVER;
			lo = `N16_UNDER;
			g = `SCALE_N16;
		end else return 16'h8000;
		if (d > hi) d = hi;
		if (d < lo) d = lo;
		if ((c == 8'h10 || c == 8'h20) && d < 0) d = 16'sh0000;
		p = ($signed(d) * $signed({16'h0000, g})) >>> 14;
		if (p > 32767) p = 32767;
		if (p < -32768) p = -32768;
		return p[15:0] ^ 16'h8000;
	endfunction

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("compares %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// One coupler access, bounded wait for its answer
	task automatic acc(input logic w, input logic s, input logic [4:0] i, input logic [7:0] d);
		int n;
		@(posedge clk);
		go <= 1'b1;
		wr <= w;
		sp <= s;
		ix <= i;
		dt <= d;
		@(posedge clk);
		go <= 1'b0;
		#1;
		for (n = 0; n < 10 && resp_v !== 1'b1; n++) wt(1);
		if (resp_v !== 1'b1) begin
			num_errors++;
			final_report();
		end
	endtask
	task automatic rdc(input string nm, input logic s, input logic [4:0] i, input logic [7:0] e);
		acc(1'b0, s, i, 8'h00);
		check(nm, resp, e);
	endtask

	// Hang guard
	initial begin
		repeat (60000) @(posedge clk);
		num_errors++;
		final_report();
	end

	initial begin
		num_errors = 0;
		cmp_count = 0;
		seed = 16'h2885; // 10373
		{go, wr, sp, ix, dt, val, short, flt} = '0;
		rst = 1'b1;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		rdc("p_rsv", 0, 0, 8'h00);
		rdc("p_short", 0, 1, 8'h00);
		rdc("p_ch0", 0, 2, 8'h12);
		rdc("p_ch1", 0, 3, 8'h12);
		for (int i = 0; i < 32; i++) begin
			if (i < 16 || i > 19) rdc("diag", 1, 5'(i), rst_diag(i));
		end
		check("en_rst", en, 2'b11);
		$display("test reset done");
		// Reserved byte ignores writes, enable keeps two bits
		seed = lfsr(seed);
		acc(1, 0, 0, seed[7:0] | 8'h01);
		rdc("p_rsv_w", 0, 0, 8'h00);
		acc(1, 0, 1, 8'hff);
		rdc("p_short_w", 0, 1, 8'h03);
		acc(1, 0, 1, 8'h00);
		$display("test params done");
		// Every range format with corners and random codes
		for (int c = 0; c < 4; c++) begin
			acc(1, 0, 2, codes[c]);
			acc(1, 0, 3, codes[c]);
			for (int j = 0; j < 8; j++) begin
				seed = lfsr(seed);
				v = (j < 4) ? corner[j] : seed;
				@(posedge clk);
				val <= {~v, v};
				wt(3);
				check("dac0", dac[0], exp_dac(codes[c], v));
				check("dac1", dac[1], exp_dac(codes[c], ~v));
				check("en", en, 2'b11);
			end
		end
		$display("test ranges done");
		acc(1, 0, 2, 8'hff);
		wt(3);
		check("en_off", en, 2'b10);
		check("dac_off", dac[0], 16'h8000);
		acc(1, 0, 3, 8'h33);
		wt(3);
		rdc("ch1_cfg", 1, 9, 8'h01);
		rdc("gen_cfg", 1, 0, 8'h88);
		rdc("grp_cfg", 1, 7, 8'h02);
		check("led_cfg", {gled, led}, 3'b110);
		acc(1, 0, 2, 8'h12);
		acc(1, 0, 3, 8'h12);
		wt(3);
		rdc("ch1_ok", 1, 9, 8'h00);
		rdc("gen_ok", 1, 0, 8'h00);
		$display("test config errors done");
		// Shorts on both pins, detection on channel 0 only
		acc(1, 0, 1, 8'h01);
		@(posedge clk);
		short <= 2'b11;
		t0 = cyc;
		wt(6);
		rdc("ch0_sc", 1, 8, 8'h08);
		rdc("ch1_sc", 1, 9, 8'h00);
		rdc("grp_sc", 1, 7, 8'h01);
		rdc("gen_sc", 1, 0, 8'h0c);
		check("led_sc", {gled, led}, 3'b101);
		for (int b = 0; b < 4; b++) begin
			acc(0, 1, 5'(16 + b), 8'h00);
			ts[8 * b +: 8] = resp;
		end
		check("ts", ts >= (t0 + 2) / 40 && ts <= (t0 + 6) / 40 + 1, 1'b1);
		@(posedge clk);
		short <= 2'b00;
		wt(6);
		rdc("gen_clr", 1, 0, 8'h00);
		check("led_clr", {gled, led}, 3'b000);
		$display("test shorts done");
		// Each general and internal fault on its own
		for (int k = 0; k < 5; k++) begin
			@(posedge clk);
			flt <= 5'(1 << k);
			wt(5);
			rdc("gen_flt", 1, 0, gen_e[k]);
			rdc("int_flt", 1, 3, int_e[k]);
		end
		@(posedge clk);
		flt <= 5'h00;
		$display("test faults done");
		final_report();
	end
endmodule // testbench
